/* File: rtl/dbgcp_defs.svh */
// Constants for the debug coprocessor access block: opcode fields, register selectors,
// control bit positions and reset values. Assumes inclusion by bare name.
`ifndef DBGCP_DEFS_SVH
`define DBGCP_DEFS_SVH

`define DBGCP_OPC1_DEBUG      3'h0
`define DBGCP_OPC2_ZERO       3'h0
`define DBGCP_CRN_C0          4'h0
`define DBGCP_CRN_C1          4'h1
`define DBGCP_CRN_C2          4'h2
`define DBGCP_CRM_C0          4'h0
`define DBGCP_CRM_C1          4'h1
`define DBGCP_CRM_C5          4'h5
`define DBGCP_DSCR_UDIS_BIT   12
`define DBGCP_DSCR_FLAGS_HI   31
`define DBGCP_DSCR_FLAGS_LO   28
`define DBGCP_DSCR_HALT_BIT   0
`define DBGCP_DSCR_RXFULL_BIT 30
`define DBGCP_DSCR_TXFULL_BIT 29
`define DBGCP_DSCR_MONEN_BIT  15
`define DBGCP_DSCR_HALTEN_BIT 14
`define DBGCP_DSCR_RESET      32'h0000_0000
`define DBGCP_WORD_ZERO       32'h0000_0000
`define DBGCP_MODE_USER       5'h10

`endif

/* File: rtl/dbgcp_pkg.sv */
// Types for the debug coprocessor access block.
// Assumes dbgcp_defs.svh is on the include path.
package dbgcp_pkg;
    // Coprocessor operation kind
    typedef enum logic [2:0] {
        DBGCP_OP_NONE = 3'b000,
        DBGCP_OP_MRC  = 3'b001,
        DBGCP_OP_MCR  = 3'b010,
        DBGCP_OP_STC  = 3'b011,
        DBGCP_OP_LDC  = 3'b100
    } dbgcp_op_t;

    // Core run state
    typedef enum logic [1:0] {
        DBGCP_RUN    = 2'b00,
        DBGCP_HALTED = 2'b01,
        DBGCP_EXC    = 2'b10
    } dbgcp_state_t;

    // Result of instruction decode
    typedef enum logic [3:0] {
        DBGCP_SEL_NONE  = 4'h0,
        DBGCP_SEL_ID    = 4'h1,
        DBGCP_SEL_TBASE = 4'h2,
        DBGCP_SEL_SELF  = 4'h3,
        DBGCP_SEL_RX    = 4'h4,
        DBGCP_SEL_TX    = 4'h5,
        DBGCP_SEL_DSCR  = 4'h6,
        DBGCP_SEL_FLAGS = 4'h7
    } dbgcp_sel_t;
endpackage : dbgcp_pkg

/* File: rtl/dbgcp_decode.sv */
// Decoder for debug coprocessor instruction fields into a register selector.
// Assumes fields already extracted by the pipeline; purely combinational.
`timescale 1ns/100ps
`include "dbgcp_defs.svh"
module dbgcp_decode (
    input  wire dbgcp_pkg::dbgcp_op_t  i_op,
    input  wire logic [2:0]            i_opc1,
    input  wire logic [3:0]            i_crn,
    input  wire logic [3:0]            i_crm,
    input  wire logic [2:0]            i_opc2,
    input  wire logic                  i_rt_is_pc,
    output dbgcp_pkg::dbgcp_sel_t      o_sel
);
    import dbgcp_pkg::*;

    logic opc_ok;

    // Opcode1 zero and opcode2 zero are needed for any MRC or MCR debug register; STC and LDC check CRn only
    assign opc_ok = (i_opc1 == `DBGCP_OPC1_DEBUG) && (i_opc2 == `DBGCP_OPC2_ZERO);

    // Map the supported encodings; all others fall to none (undefined)
    always_comb begin
        o_sel = DBGCP_SEL_NONE;
        case (i_op)
            DBGCP_OP_MRC: begin
                if (opc_ok && i_crm == `DBGCP_CRM_C0 && i_crn == `DBGCP_CRN_C0) begin
                    o_sel = DBGCP_SEL_ID;
                end else if (opc_ok && i_crm == `DBGCP_CRM_C0 && i_crn == `DBGCP_CRN_C1) begin
                    o_sel = DBGCP_SEL_TBASE;
                end else if (opc_ok && i_crm == `DBGCP_CRM_C0 && i_crn == `DBGCP_CRN_C2) begin
                    o_sel = DBGCP_SEL_SELF;
                end else if (opc_ok && i_crm == `DBGCP_CRM_C5 && i_crn == `DBGCP_CRN_C0) begin
                    o_sel = DBGCP_SEL_RX;
                end else if (opc_ok && i_crm == `DBGCP_CRM_C1 && i_crn == `DBGCP_CRN_C0) begin
                    o_sel = i_rt_is_pc ? DBGCP_SEL_FLAGS : DBGCP_SEL_DSCR;
                end
            end
            DBGCP_OP_MCR: begin
                if (opc_ok && i_crm == `DBGCP_CRM_C5 && i_crn == `DBGCP_CRN_C0) begin
                    o_sel = DBGCP_SEL_TX;
                end
            end
            DBGCP_OP_STC: begin
                if (i_crn == `DBGCP_CRM_C5) begin
                    o_sel = DBGCP_SEL_RX;
                end
            end
            DBGCP_OP_LDC: begin
                if (i_crn == `DBGCP_CRM_C5) begin
                    o_sel = DBGCP_SEL_TX;
                end
            end
            default: o_sel = DBGCP_SEL_NONE;
        endcase
    end
endmodule : dbgcp_decode

/* File: rtl/dbgcp_access.sv */
// Debug coprocessor access and halting/monitor control for one core.
// Assumes pipeline presents one coprocessor request per cycle with a strobe, and that the
// APB slave elsewhere drives the debugger-side transfer and control strobes given here.
// Debugger-side strobes are single-cycle pulses, and the status view shown to it is live.
`timescale 1ns/100ps
`include "dbgcp_defs.svh"
module dbgcp_access #(
    parameter logic [31:0] ID_VALUE    = 32'h0000_0000, // Arbitrary identification value
    parameter logic [31:0] TBASE_VALUE = 32'h0000_0000,
    parameter logic [31:0] SELF_VALUE  = 32'h0000_0000,
    parameter int          DATA_W      = 32
) (
    input  wire logic                  I_CORE_CLK,
    input  wire logic                  I_RST,
    // Pipeline request
    input  wire logic                  i_cp_valid,
    input  wire dbgcp_pkg::dbgcp_op_t  i_cp_op,
    input  wire logic [2:0]            i_cp_opc1,
    input  wire logic [3:0]            i_cp_crn,
    input  wire logic [3:0]            i_cp_crm,
    input  wire logic [2:0]            i_cp_opc2,
    input  wire logic                  i_cp_rt_is_pc,
    input  wire logic [DATA_W-1:0]     i_cp_wdata,
    input  wire logic [4:0]            i_cpu_mode,
    input  wire logic                  i_debug_event,
    input  wire logic                  i_restart,
    // Debugger side, from the APB3 slave of this core
    input  wire logic                  i_ext_dscr_we,
    input  wire logic [DATA_W-1:0]     i_ext_dscr_wdata,
    input  wire logic                  i_ext_rx_we,
    input  wire logic [DATA_W-1:0]     i_ext_rx_wdata,
    input  wire logic                  i_ext_tx_re,
    // Pipeline answer
    output logic                       o_cp_done,
    output logic                       o_cp_undef,
    output logic [DATA_W-1:0]          o_cp_rdata,
    output logic                       o_cp_flags_we,
    output logic [3:0]                 o_cp_flags,
    // Core control
    output logic                       o_halted,
    output logic                       o_debug_exc,
    // Debugger side outputs
    output logic [DATA_W-1:0]          o_ext_dscr,
    output logic [DATA_W-1:0]          o_ext_tx_data
);
    import dbgcp_pkg::*;

    // Elaboration check: the status view and the flag slice assume a 32-bit word
    if (DATA_W != 32) begin : g_width_check
        $error("dbgcp_access: DATA_W must be 32");
    end

    // All module state in one record
    typedef struct packed {
        dbgcp_state_t        st;
        logic [DATA_W-1:0]   dscr;
        logic [DATA_W-1:0]   rx;
        logic [DATA_W-1:0]   tx;
        logic                rx_full;
        logic                tx_full;
        logic                done;
        logic                undef;
        logic                flags_we;
        logic [3:0]          flags;
        logic [DATA_W-1:0]   rdata;
        logic                exc;
    } dbgcp_regs_t;

    dbgcp_regs_t r_r;
    dbgcp_regs_t r_nxt;
    dbgcp_sel_t  sel;
    logic        in_debug;
    logic        user_mode;
    logic        permit;
    logic [DATA_W-1:0] dscr_view;

    dbgcp_decode u_decode (
        .i_op       (i_cp_op),
        .i_opc1     (i_cp_opc1),
        .i_crn      (i_cp_crn),
        .i_crm      (i_cp_crm),
        .i_opc2     (i_cp_opc2),
        .i_rt_is_pc (i_cp_rt_is_pc),
        .o_sel      (sel)
    );

    // Permission check; debug state overrides mode and disable bit
    assign in_debug  = (r_r.st == DBGCP_HALTED);
    assign user_mode = (i_cpu_mode == `DBGCP_MODE_USER);
    assign permit    = in_debug
                     || !user_mode
                     || !r_r.dscr[`DBGCP_DSCR_UDIS_BIT];

    // Internal status view with live halt and channel flags
    // Bits 0, 29 and 30 are overlaid so that no reader sees a stale copy
    always_comb begin
        dscr_view = r_r.dscr;
        dscr_view[`DBGCP_DSCR_HALT_BIT]   = in_debug;
        dscr_view[`DBGCP_DSCR_RXFULL_BIT] = r_r.rx_full;
        dscr_view[`DBGCP_DSCR_TXFULL_BIT] = r_r.tx_full;
    end

    // Next-state logic
    always_comb begin
        r_nxt          = r_r;
        r_nxt.done     = 1'b0;
        r_nxt.undef    = 1'b0;
        r_nxt.flags_we = 1'b0;
        r_nxt.exc      = 1'b0;

        // Debugger-side accesses through the per-core APB3 port
        if (i_ext_dscr_we) begin
            r_nxt.dscr = i_ext_dscr_wdata;
        end
        if (i_ext_rx_we) begin
            r_nxt.rx      = i_ext_rx_wdata;
            r_nxt.rx_full = 1'b1;
        end
        if (i_ext_tx_re) begin
            r_nxt.tx_full = 1'b0;
        end

        // Coprocessor instruction
        if (i_cp_valid) begin
            r_nxt.done = 1'b1;
            // A refused access has no side effect; it only answers with undef
            if (sel == DBGCP_SEL_NONE) begin
                r_nxt.undef = 1'b1;
            end else if (!permit) begin
                r_nxt.undef = 1'b1;
            end else begin
                case (sel)
                    DBGCP_SEL_ID:    r_nxt.rdata = ID_VALUE;
                    DBGCP_SEL_TBASE: r_nxt.rdata = TBASE_VALUE;
                    DBGCP_SEL_SELF:  r_nxt.rdata = SELF_VALUE;
                    DBGCP_SEL_RX: begin
                        r_nxt.rdata = r_r.rx;
                        // A debugger write in the same cycle keeps the word full: set wins
                        if (!i_ext_rx_we) begin
                            r_nxt.rx_full = 1'b0;
                        end
                    end
                    DBGCP_SEL_TX: begin
                        // Applied after a same-cycle debugger read, so tx stays full: set wins
                        r_nxt.tx      = i_cp_wdata;
                        r_nxt.tx_full = 1'b1;
                    end
                    DBGCP_SEL_DSCR:  r_nxt.rdata = dscr_view;
                    DBGCP_SEL_FLAGS: begin
                        r_nxt.flags    = dscr_view[`DBGCP_DSCR_FLAGS_HI:`DBGCP_DSCR_FLAGS_LO];
                        r_nxt.flags_we = 1'b1;
                    end
                    default: r_nxt.undef = 1'b1;
                endcase
            end
        end

        // Debug method selection on a debug event
        // Halting wins when both methods are enabled; events are ignored while
        // halted and in the single exception cycle
        case (r_r.st)
            DBGCP_RUN: begin
                if (i_debug_event) begin
                    if (r_r.dscr[`DBGCP_DSCR_HALTEN_BIT]) begin
                        r_nxt.st = DBGCP_HALTED;
                    end else if (r_r.dscr[`DBGCP_DSCR_MONEN_BIT]) begin
                        r_nxt.st  = DBGCP_EXC;
                        r_nxt.exc = 1'b1;
                    end
                end
            end
            DBGCP_HALTED: begin
                if (i_restart) begin
                    r_nxt.st = DBGCP_RUN;
                end
            end
            DBGCP_EXC: r_nxt.st = DBGCP_RUN;
            default:   r_nxt.st = DBGCP_RUN;
        endcase
    end

    // State register
    // Reset loads constants only; the status register returns with no method enabled
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            r_r <= '{st: DBGCP_RUN, dscr: `DBGCP_DSCR_RESET, rx: `DBGCP_WORD_ZERO,
                     tx: `DBGCP_WORD_ZERO, rx_full: 1'b0, tx_full: 1'b0, done: 1'b0,
                     undef: 1'b0, flags_we: 1'b0, flags: 4'h0, rdata: `DBGCP_WORD_ZERO,
                     exc: 1'b0};
        end else begin
            r_r <= r_nxt;
        end
    end

    // Outputs
    assign o_cp_done     = r_r.done;
    assign o_cp_undef    = r_r.undef;
    assign o_cp_rdata    = r_r.rdata;
    assign o_cp_flags_we = r_r.flags_we;
    assign o_cp_flags    = r_r.flags;
    // Halt flag comes straight from the state field so it never lags the status view
    assign o_halted      = in_debug;
    assign o_debug_exc   = r_r.exc;
    assign o_ext_dscr    = dscr_view;
    assign o_ext_tx_data = r_r.tx;
endmodule : dbgcp_access

/* File: test/dbgcp_access_monitor.sv */
// Checker for the debug coprocessor access block.
// Assumes it is bound to dbgcp_access and sees only its ports.
`timescale 1ns/100ps
module dbgcp_access_monitor (
    input wire logic                 I_CORE_CLK,
    input wire logic                 I_RST,
    input wire logic                 i_cp_valid,
    input wire dbgcp_pkg::dbgcp_op_t i_cp_op,
    input wire logic [2:0]           i_cp_opc1,
    input wire logic [3:0]           i_cp_crn,
    input wire logic [3:0]           i_cp_crm,
    input wire logic [2:0]           i_cp_opc2,
    input wire logic                 i_cp_rt_is_pc,
    input wire logic [4:0]           i_cpu_mode,
    input wire logic                 i_debug_event,
    input wire logic                 o_cp_done,
    input wire logic                 o_cp_undef,
    input wire logic                 o_cp_flags_we,
    input wire logic                 o_halted,
    input wire logic                 o_debug_exc,
    input wire logic [31:0]          o_ext_dscr
);
    import dbgcp_pkg::*;
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RST);
    // Register transfer, zero fields on c0, user lock, an event that may act, a status read
    wire rw = i_cp_valid && (i_cp_op == DBGCP_OP_MRC || i_cp_op == DBGCP_OP_MCR);
    wire c0 = i_cp_valid && i_cp_opc1 == 3'h0 && i_cp_opc2 == 3'h0 && i_cp_crn == 4'h0;
    wire lock = i_cpu_mode == 5'h10 && o_ext_dscr[12] && !o_halted;
    wire ev = i_debug_event && !o_halted && !o_debug_exc;
    wire sc = c0 && i_cp_op == DBGCP_OP_MRC && i_cp_crm == 4'h1;
    a_done_next: assert property (i_cp_valid |=> o_cp_done)
        else $error("no answer");
    a_undef_cause: assert property (o_cp_undef |-> o_cp_done && $past(i_cp_valid))
        else $error("stray undef");
    a_user_lock: assert property (i_cp_valid && lock |=> o_cp_undef)
        else $error("locked access done");
    a_debug_open: assert property (o_halted && sc |=> !o_cp_undef)
        else $error("halted access refused");
    a_priv_open: assert property (i_cpu_mode != 5'h10 && sc |=> !o_cp_undef)
        else $error("privileged access refused");
    a_opc1_undef: assert property (rw && i_cp_opc1 != 3'h0 |=> o_cp_undef)
        else $error("opcode1 accepted");
    a_halt_event: assert property (ev && o_ext_dscr[14] |=> o_halted)
        else $error("no halt");
    a_monitor_exc: assert property (ev && o_ext_dscr[15:14] == 2'h2 |=> o_debug_exc && !o_halted)
        else $error("no debug exception");
    a_flags_pulse: assert property (sc && !lock && i_cp_rt_is_pc |=> o_cp_flags_we)
        else $error("no flags write");
    c_halt_access: cover property (o_halted && i_cp_valid);
    c_exc: cover property (o_debug_exc);
    c_locked: cover property (i_cp_valid && lock);
endmodule : dbgcp_access_monitor

/* File: test/dbgcp_dbg_model.sv */
// Debugger model: drives the status, receive and transmit strobes of one core.
// Assumes access() is called just after a rising clock edge.
`timescale 1ns/100ps
module dbgcp_dbg_model (
    input  wire logic        i_clk,
    input  wire logic [31:0] i_tx_data,
    output logic             o_dscr_we,
    output logic             o_rx_we,
    output logic             o_tx_re,
    output logic [31:0]      o_wdata
);
    // Idle at time zero
    initial {o_wdata, o_dscr_we, o_rx_we, o_tx_re} = 35'h0;
    // One access after g idle cycles; data inverted on release
    task automatic access(input int s, input logic [31:0] d, input int g, output logic [31:0] r);
        repeat (g) begin
            @(posedge i_clk);
            #1;
        end
        {o_wdata, o_dscr_we, o_rx_we, o_tx_re} = {d, s == 0, s == 1, s == 2};
        @(posedge i_clk);
        r = i_tx_data;
        #1;
        {o_wdata, o_dscr_we, o_rx_we, o_tx_re} = {~d, 3'h0};
    endtask : access
endmodule : dbgcp_dbg_model

/* File: test/debug_coproc_access_test.sv */
// Self-checking bench for the debug coprocessor access block.
// Assumes design, checker and debugger model are compiled first.
`timescale 1ns/100ps
module debug_coproc_access_test;
    import dbgcp_pkg::*;
    localparam logic [31:0] ID_V = 32'hA5A5_0001; // Arbitrary value
    localparam logic [31:0] TB_V = 32'h0001_0000;
    localparam logic [31:0] SF_V = 32'h0002_0000;
    dbgcp_op_t   op;
    logic        clk, rst, v, pc, ev, rs, dwe, rwe, tre, done, und, fwe, hlt, exc, m_rf, m_tf, m_h;
    logic [2:0]  o1, o2;
    logic [3:0]  n, m, fl;
    logic [4:0]  md;
    logic [31:0] wd, hd, rd, ds, tx, sd, m_ds, m_rx, m_tx, m_rd;
    int          err_total, total_checks, cyc;
    dbgcp_access #(.ID_VALUE(ID_V), .TBASE_VALUE(TB_V), .SELF_VALUE(SF_V)) uut (
        .I_CORE_CLK(clk), .I_RST(rst), .i_cp_valid(v), .i_cp_op(op), .i_cp_opc1(o1), .i_cp_crn(n),
        .i_cp_crm(m), .i_cp_opc2(o2), .i_cp_rt_is_pc(pc), .i_cp_wdata(wd), .i_cpu_mode(md),
        .i_debug_event(ev), .i_restart(rs), .i_ext_dscr_we(dwe), .i_ext_dscr_wdata(hd), .i_ext_rx_we(rwe),
        .i_ext_rx_wdata(hd), .i_ext_tx_re(tre), .o_cp_done(done), .o_cp_undef(und), .o_cp_rdata(rd),
        .o_cp_flags_we(fwe), .o_cp_flags(fl), .o_halted(hlt), .o_debug_exc(exc), .o_ext_dscr(ds),
        .o_ext_tx_data(tx));
    dbgcp_dbg_model dbg (.i_clk(clk), .i_tx_data(tx), .o_dscr_we(dwe), .o_rx_we(rwe), .o_tx_re(tre), .o_wdata(hd));
    // Clock, and a cycle ceiling against hangs
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            err_total++;
            tally_and_finish();
        end
    end
    function automatic logic [31:0] rnd();
        sd = sd ^ (sd << 13);
        sd = sd ^ (sd >> 17);
        sd = sd ^ (sd << 5);
        return sd;
    endfunction : rnd
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Debugger access, mirrored in the bench model
    task automatic host(input int s, input logic [31:0] d, input int g);
        logic [31:0] r;
        dbg.access(s, d, g, r);
        if (s == 0) m_ds = d;
        if (s == 1) {m_rx, m_rf} = {d, 1'b1};
        if (s == 2) begin
            chk(r, m_tx);
            m_tf = 1'b0;
        end
        chk(ds, {m_ds[31], m_rf, m_tf, m_ds[28:1], m_h});
    endtask : host
    // One instruction, answer checked one cycle later
    task automatic cp(input dbgcp_op_t o, input logic [2:0] a, input logic [3:0] nn, input logic [3:0] mm,
                      input logic [2:0] b, input logic p);
        logic [7:0]  nm;
        logic        ok, lk;
        logic [31:0] vw;
        nm = {nn, mm};
        vw = {m_ds[31], m_rf, m_tf, m_ds[28:1], m_h};
        ok = o == DBGCP_OP_MRC && a == 0 && b == 0 && (nm == 8'h01 || !p && nm inside {8'h00, 8'h10, 8'h20, 8'h05});
        ok = ok || o == DBGCP_OP_MCR && a == 0 && b == 0 && !p && nm == 8'h05;
        ok = ok || o inside {DBGCP_OP_STC, DBGCP_OP_LDC} && nn == 4'h5;
        lk = md == 5'h10 && m_ds[12] && !m_h;
        op = o;
        {o1, n, m, o2, pc, wd, v} = {a, nn, mm, b, p, rnd(), 1'b1};
        @(posedge clk);
        #1;
        v = 1'b0;
        if (ok && !lk) begin
            if (o == DBGCP_OP_MRC && !p) begin
                m_rd = nm == 8'h00 ? ID_V : nm == 8'h10 ? TB_V : nm == 8'h20 ? SF_V : nm == 8'h01 ? vw : m_rx;
            end
            if (o == DBGCP_OP_STC) m_rd = m_rx;
            if (o == DBGCP_OP_STC || o == DBGCP_OP_MRC && nm == 8'h05) m_rf = 1'b0;
            if (o == DBGCP_OP_MCR || o == DBGCP_OP_LDC) {m_tx, m_tf} = {wd, 1'b1};
        end
        chk(done, 1);
        chk(und, !ok || lk);
        chk(fwe, ok && !lk && p);
        if (ok && !lk && p) chk(fl, vw[31:28]);
        chk(rd, m_rd);
        chk(tx, m_tx);
        chk(ds, {m_ds[31], m_rf, m_tf, m_ds[28:1], m_h});
        @(posedge clk);
        #1;
    endtask : cp
    // Debug event (r low) or restart (r high)
    task automatic evt(input logic r);
        logic x;
        x = !r && !m_h && m_ds[15:14] == 2'h2;
        {ev, rs} = {!r, r};
        @(posedge clk);
        #1;
        {ev, rs} = 2'h0;
        if (!r && m_ds[14]) m_h = 1'b1;
        chk(exc, x);
        if (!r) chk(hlt, m_h);
        m_h = m_h && !r;
        @(posedge clk);
        #1;
        chk({hlt, exc}, {m_h, 1'b0});
    endtask : evt
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish
    // Reset, decode table in both modes, lock and flags, halting and monitor events
    initial begin
        rst = 1'b1;
        op = DBGCP_OP_NONE;
        {v, pc, ev, rs, o1, n, m, o2, wd, md} = 55'h0;
        {m_ds, m_rx, m_tx, m_rd, m_rf, m_tf, m_h} = 131'h0;
        sd = 32'h0000_D339;
        repeat (5) @(posedge clk);
        #1;
        rst = 1'b0;
        chk(ds | rd | tx, 0);
        chk({done, hlt, exc}, 0);
        for (int k = 0; k < 2; k++) begin
            md = k ? 5'h10 : 5'h1F;
            host(1, rnd(), 3 * k);
            cp(DBGCP_OP_MRC, 0, 0, 0, 0, 0);
            cp(DBGCP_OP_MRC, 0, 1, 0, 0, 0);
            cp(DBGCP_OP_MRC, 0, 2, 0, 0, 0);
            cp(DBGCP_OP_MRC, 0, 0, 5, 0, 0);
            host(1, rnd(), k);
            cp(DBGCP_OP_STC, 0, 5, 0, 0, 0);
            cp(DBGCP_OP_MCR, 0, 0, 5, 0, 0);
            host(2, 0, k);
            cp(DBGCP_OP_LDC, 0, 5, 0, 0, 0);
            host(2, 0, 0);
            cp(DBGCP_OP_MRC, 1, 0, 0, 0, 0);
            cp(DBGCP_OP_MRC, 0, 3, 0, 0, 0);
            cp(DBGCP_OP_MRC, 0, 0, 0, 1, 0);
            cp(DBGCP_OP_MCR, 0, 0, 0, 0, 0);
        end
        host(0, 32'h9000_1000, 0);
        md = 5'h13;
        cp(DBGCP_OP_MRC, 0, 0, 1, 0, 1);
        cp(DBGCP_OP_MRC, 0, 0, 1, 0, 0);
        md = 5'h10;
        cp(DBGCP_OP_MCR, 0, 0, 5, 0, 0);
        cp(DBGCP_OP_MRC, 0, 0, 0, 0, 0);
        host(0, 32'h0000_5000, 0);
        evt(0);
        cp(DBGCP_OP_MRC, 0, 0, 1, 0, 0);
        evt(0);
        evt(1);
        host(0, 32'h0000_8000, 2);
        evt(0);
        host(0, 32'h0000_C000, 0);
        evt(0);
        evt(1);
        tally_and_finish();
    end
endmodule : debug_coproc_access_test
bind dbgcp_access dbgcp_access_monitor u_monitor (
    .I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .i_cp_valid(i_cp_valid), .i_cp_op(i_cp_op),
    .i_cp_opc1(i_cp_opc1), .i_cp_crn(i_cp_crn), .i_cp_crm(i_cp_crm), .i_cp_opc2(i_cp_opc2),
    .i_cp_rt_is_pc(i_cp_rt_is_pc), .i_cpu_mode(i_cpu_mode), .i_debug_event(i_debug_event),
    .o_cp_done(o_cp_done), .o_cp_undef(o_cp_undef), .o_cp_flags_we(o_cp_flags_we), .o_halted(o_halted),
    .o_debug_exc(o_debug_exc), .o_ext_dscr(o_ext_dscr));
